// [core/lltm_pkg.sv]
// Shared constants and types for the line timing and line-lock PLL control registers
package lltm_pkg;
  localparam int        TIME_W           = 10;
  localparam int        HI_W             = 2;
  localparam int        LO_W             = 8;
  localparam logic [7:0] ADDR_LSYNC_END_HI = 8'h0f;
  localparam logic [7:0] ADDR_FILTER_ADJ   = 8'h10;
  localparam logic [7:0] ADDR_DETECT_WIN   = 8'h11;
  localparam logic [7:0] ADDR_RST_START_LO = 8'h12;
  localparam logic [7:0] ADDR_RST_START_HI = 8'h13;
  localparam logic [7:0] ADDR_RST_END_LO   = 8'h14;
  localparam logic [7:0] ADDR_RST_END_HI   = 8'h15;
  localparam logic [1:0] RST_LSYNC_END_HI  = 2'h0;
  localparam logic [7:0] RST_FILTER_ADJ    = 8'h00;
  localparam logic [7:0] RST_DETECT_WIN    = 8'hdd;
  localparam logic [7:0] RST_RST_START_LO  = 8'h3f;
  localparam logic [1:0] RST_RST_START_HI  = 2'h0;
  localparam logic [7:0] RST_RST_END_LO    = 8'h52;
  localparam logic [1:0] RST_RST_END_HI    = 2'h0;
  localparam logic [7:0] MISS_CNT_MAX      = 8'hff;
  localparam int         NUM_PULSES        = 2;
  localparam int         PULSE_LSYNC       = 0;
  localparam int         PULSE_RESTORE     = 1;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lltm_req_t;
endpackage

// [core/lltm_window_pulse.sv]
// Registered pulse that is high while a line count lies in a start/end window
`timescale 1ns/1ns
module lltm_window_pulse #(
  parameter int TIME_W = 10
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic [TIME_W-1:0] cnt,
  input  wire logic [TIME_W-1:0] start_time,
  input  wire logic [TIME_W-1:0] end_time,
  output logic                   pulse
);
  logic in_window;
  logic pulse_reg;

  assign in_window = (cnt >= start_time) && (cnt < end_time);
  assign pulse     = pulse_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= in_window;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_pulse_in_window: assert property (
    ##1 pulse == ($past(cnt) >= $past(start_time) && $past(cnt) < $past(end_time)))
    else $error("window pulse does not follow start and end times");
endmodule

// [core/lltm_line_timing_regs.sv]
// Line timing and line-lock PLL control registers with pulse timing and missing sync count
`timescale 1ns/1ns
// Contract
// - Line sync output pulse end is a 10-bit delay; top two bits at 0x0f.
// - Unused upper bits of upper timing registers ignore writes and read zero.
// - Lower register holds value bits 7..0, upper register holds bits 9..8.
// - Loop filter adjust at 0x10 steers PLL time constants, resets to 0x00.
// - Sync detect window at 0x11, reset 0xdd, sets hsync acceptance length.
// - Hsync outside the detect window is missing and advances the missing counter.
// - Restore pulse start is 10-bit: low byte 0x12, high bits 0x13.
// - Restore start low byte resets to 0x3f, high bits to zero.
// - Restore pulse end: low byte 0x14 reset 0x52, high bits 0x15 reset zero.
module lltm_line_timing_regs #(
  parameter int TIME_W = lltm_pkg::TIME_W
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  input  wire lltm_pkg::lltm_req_t     reg_req,
  output logic [7:0]                   reg_rdata,
  output logic                         reg_rvalid,
  input  wire logic                    line_start,
  input  wire logic                    hsync_in,
  input  wire logic [TIME_W-1:0]       line_sync_start,
  input  wire logic [7:0]              line_sync_end_low,
  output logic                         line_sync_out,
  output logic                         black_level_restore_pulse,
  output logic [7:0]                   pll_filter_adjust,
  output logic [7:0]                   pll_detect_window,
  output logic                         hsync_missing,
  output logic [7:0]                   missing_sync_count
);
  import lltm_pkg::*;

  generate
    if (TIME_W != HI_W + LO_W) begin : g_bad_width
      $error("TIME_W must equal the split of upper and lower timing registers");
    end
  endgenerate

  logic [HI_W-1:0]   lsync_end_hi_reg;
  logic [7:0]        filter_adj_reg;
  logic [7:0]        detect_win_reg;
  logic [7:0]        rst_start_lo_reg;
  logic [HI_W-1:0]   rst_start_hi_reg;
  logic [7:0]        rst_end_lo_reg;
  logic [HI_W-1:0]   rst_end_hi_reg;
  logic [7:0]        rdata_reg;
  logic              rvalid_reg;
  logic [TIME_W-1:0] pix_cnt_reg;
  logic              missing_reg;
  logic [7:0]        miss_cnt_reg;

  wire wr_lsync_end_hi = reg_req.wr && (reg_req.addr == ADDR_LSYNC_END_HI);
  wire wr_filter_adj   = reg_req.wr && (reg_req.addr == ADDR_FILTER_ADJ);
  wire wr_detect_win   = reg_req.wr && (reg_req.addr == ADDR_DETECT_WIN);
  wire wr_rst_start_lo = reg_req.wr && (reg_req.addr == ADDR_RST_START_LO);
  wire wr_rst_start_hi = reg_req.wr && (reg_req.addr == ADDR_RST_START_HI);
  wire wr_rst_end_lo   = reg_req.wr && (reg_req.addr == ADDR_RST_END_LO);
  wire wr_rst_end_hi   = reg_req.wr && (reg_req.addr == ADDR_RST_END_HI);

  // Upper timing registers keep only two bits; the rest read as zero
  wire [7:0] rd_lsync_end_hi = {6'h00, lsync_end_hi_reg};
  wire [7:0] rd_rst_start_hi = {6'h00, rst_start_hi_reg};
  wire [7:0] rd_rst_end_hi   = {6'h00, rst_end_hi_reg};

  wire [7:0] rdata_next =
    (reg_req.addr == ADDR_LSYNC_END_HI) ? rd_lsync_end_hi :
    (reg_req.addr == ADDR_FILTER_ADJ)   ? filter_adj_reg :
    (reg_req.addr == ADDR_DETECT_WIN)   ? detect_win_reg :
    (reg_req.addr == ADDR_RST_START_LO) ? rst_start_lo_reg :
    (reg_req.addr == ADDR_RST_START_HI) ? rd_rst_start_hi :
    (reg_req.addr == ADDR_RST_END_LO)   ? rst_end_lo_reg :
    (reg_req.addr == ADDR_RST_END_HI)   ? rd_rst_end_hi : 8'h00;

  // Assembled 10-bit times, high bits above the low byte
  wire [TIME_W-1:0] lsync_end_time = {lsync_end_hi_reg, line_sync_end_low};
  wire [TIME_W-1:0] rst_start_time = {rst_start_hi_reg, rst_start_lo_reg};
  wire [TIME_W-1:0] rst_end_time   = {rst_end_hi_reg, rst_end_lo_reg};

  wire [TIME_W-1:0] cnt_max      = {TIME_W{1'b1}};
  wire [TIME_W-1:0] pix_cnt_next = line_start ? '0 :
                                   (pix_cnt_reg == cnt_max) ? pix_cnt_reg :
                                   pix_cnt_reg + 1'b1;

  wire       in_detect_win = pix_cnt_reg < {{(TIME_W-8){1'b0}}, detect_win_reg};
  wire       miss_event    = hsync_in && !in_detect_win;
  wire [7:0] miss_cnt_next = (miss_event && miss_cnt_reg != MISS_CNT_MAX) ?
                             miss_cnt_reg + 8'h01 : miss_cnt_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lsync_end_hi_reg <= RST_LSYNC_END_HI;
      filter_adj_reg   <= RST_FILTER_ADJ;
      detect_win_reg   <= RST_DETECT_WIN;
      rst_start_lo_reg <= RST_RST_START_LO;
      rst_start_hi_reg <= RST_RST_START_HI;
      rst_end_lo_reg   <= RST_RST_END_LO;
      rst_end_hi_reg   <= RST_RST_END_HI;
    end else begin
      if (wr_lsync_end_hi) begin
        lsync_end_hi_reg <= reg_req.wdata[HI_W-1:0];
      end
      if (wr_filter_adj) begin
        filter_adj_reg <= reg_req.wdata;
      end
      if (wr_detect_win) begin
        detect_win_reg <= reg_req.wdata;
      end
      if (wr_rst_start_lo) begin
        rst_start_lo_reg <= reg_req.wdata;
      end
      if (wr_rst_start_hi) begin
        rst_start_hi_reg <= reg_req.wdata[HI_W-1:0];
      end
      if (wr_rst_end_lo) begin
        rst_end_lo_reg <= reg_req.wdata;
      end
      if (wr_rst_end_hi) begin
        rst_end_hi_reg <= reg_req.wdata[HI_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_req.rd;
      if (reg_req.rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pix_cnt_reg  <= '0;
      missing_reg  <= 1'b0;
      miss_cnt_reg <= 8'h00;
    end else begin
      pix_cnt_reg  <= pix_cnt_next;
      missing_reg  <= miss_event;
      miss_cnt_reg <= miss_cnt_next;
    end
  end

  wire [TIME_W-1:0] pulse_start [NUM_PULSES];
  wire [TIME_W-1:0] pulse_end   [NUM_PULSES];
  wire              pulse_out   [NUM_PULSES];

  assign pulse_start[PULSE_LSYNC]   = line_sync_start;
  assign pulse_end[PULSE_LSYNC]     = lsync_end_time;
  assign pulse_start[PULSE_RESTORE] = rst_start_time;
  assign pulse_end[PULSE_RESTORE]   = rst_end_time;

  generate
    for (genvar i = 0; i < NUM_PULSES; i++) begin : g_pulse
      lltm_window_pulse #(
        .TIME_W (TIME_W)
      ) u_pulse (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .cnt        (pix_cnt_reg),
        .start_time (pulse_start[i]),
        .end_time   (pulse_end[i]),
        .pulse      (pulse_out[i])
      );
    end
  endgenerate

  assign reg_rdata                 = rdata_reg;
  assign reg_rvalid                = rvalid_reg;
  assign line_sync_out             = pulse_out[PULSE_LSYNC];
  assign black_level_restore_pulse = pulse_out[PULSE_RESTORE];
  assign pll_filter_adjust         = filter_adj_reg;
  assign pll_detect_window         = detect_win_reg;
  assign hsync_missing             = missing_reg;
  assign missing_sync_count        = miss_cnt_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_read_hi_reg;
    reg_req.rd && (reg_req.addr == ADDR_LSYNC_END_HI || reg_req.addr == ADDR_RST_START_HI ||
                   reg_req.addr == ADDR_RST_END_HI);
  endsequence

  wire rd_alone = reg_req.rd && !reg_req.wr;

  // Write, one quiet cycle, then a lone read of the same register
  sequence s_lsync_hi_wr_rd;
    wr_lsync_end_hi ##1 !reg_req.wr ##1 (rd_alone && reg_req.addr == ADDR_LSYNC_END_HI);
  endsequence
  sequence s_start_hi_wr_rd;
    wr_rst_start_hi ##1 !reg_req.wr ##1 (rd_alone && reg_req.addr == ADDR_RST_START_HI);
  endsequence
  sequence s_end_hi_wr_rd;
    wr_rst_end_hi ##1 !reg_req.wr ##1 (rd_alone && reg_req.addr == ADDR_RST_END_HI);
  endsequence
  sequence s_start_lo_wr_rd;
    wr_rst_start_lo ##1 !reg_req.wr ##1 (rd_alone && reg_req.addr == ADDR_RST_START_LO);
  endsequence
  sequence s_end_lo_wr_rd;
    wr_rst_end_lo ##1 !reg_req.wr ##1 (rd_alone && reg_req.addr == ADDR_RST_END_LO);
  endsequence
  sequence s_filter_wr_rd;
    wr_filter_adj ##1 !reg_req.wr ##1 (rd_alone && reg_req.addr == ADDR_FILTER_ADJ);
  endsequence

  a_hi_unused_zero: assert property (
    s_read_hi_reg |=> reg_rvalid && reg_rdata[7:2] == 6'h00)
    else $error("unused upper timing bits read nonzero");
  a_filter_write: assert property (
    wr_filter_adj |=> pll_filter_adjust == $past(reg_req.wdata))
    else $error("loop filter adjust not stored");
  a_window_write: assert property (
    wr_detect_win |=> ##1 (rd_alone && reg_req.addr == ADDR_DETECT_WIN) |=>
    reg_rdata == pll_detect_window)
    else $error("detect window readback mismatch");
  a_split_start: assert property (
    wr_rst_start_hi && !wr_rst_start_lo |=>
    rst_start_time[9:8] == $past(reg_req.wdata[1:0]) &&
    rst_start_time[7:0] == $past(rst_start_lo_reg))
    else $error("restore start split wrong");
  a_split_end: assert property (
    wr_rst_end_lo |=>
    rst_end_time == {$past(rst_end_hi_reg), $past(reg_req.wdata)})
    else $error("restore end split wrong");
  a_lsync_end_hi: assert property (
    wr_lsync_end_hi |=> lsync_end_time[9:8] == $past(reg_req.wdata[1:0]))
    else $error("line sync end high bits not stored");
  a_miss_count: assert property (
    miss_event && miss_cnt_reg != MISS_CNT_MAX |=>
    missing_sync_count == $past(miss_cnt_reg) + 8'h01 && hsync_missing)
    else $error("missing sync not counted");
  a_miss_saturate: assert property (
    miss_event && miss_cnt_reg == MISS_CNT_MAX |=>
    missing_sync_count == MISS_CNT_MAX && hsync_missing)
    else $error("missing sync count left saturation");
  a_sync_accept: assert property (
    hsync_in && in_detect_win |=> !hsync_missing && $stable(missing_sync_count))
    else $error("hsync inside window counted as missing");
  a_sync_absent: assert property (
    !hsync_in |=> !hsync_missing && $stable(missing_sync_count))
    else $error("missing sync flagged without an hsync");
  a_restore_reset: assert property (
    $rose(rstn) |-> rst_start_time == 10'h03f &&
    rst_end_time == 10'h052)
    else $error("restore times wrong after reset");
  a_ctrl_reset: assert property (
    $rose(rstn) |-> lsync_end_hi_reg == RST_LSYNC_END_HI &&
    pll_filter_adjust == RST_FILTER_ADJ && pll_detect_window == RST_DETECT_WIN)
    else $error("control registers wrong after reset");
  a_line_count: assert property (
    line_start |=> (pix_cnt_reg == '0) ##1
    (pix_cnt_reg == ($past(line_start) ? '0 : 10'h001)))
    else $error("pixel count not restarted at line start");
  a_count_step: assert property (
    !line_start && pix_cnt_reg != cnt_max |=> pix_cnt_reg == $past(pix_cnt_reg) + 1'b1)
    else $error("pixel count did not advance");
  a_count_hold: assert property (
    !line_start && pix_cnt_reg == cnt_max |=> pix_cnt_reg == cnt_max)
    else $error("pixel count left saturation");
  a_restore_on: assert property (
    pix_cnt_reg >= rst_start_time && pix_cnt_reg < rst_end_time |=> black_level_restore_pulse)
    else $error("restore pulse missing inside its window");
  a_restore_off: assert property (
    pix_cnt_reg < rst_start_time || pix_cnt_reg >= rst_end_time |=> !black_level_restore_pulse)
    else $error("restore pulse outside its window");
  a_lsync_on: assert property (
    pix_cnt_reg >= line_sync_start && pix_cnt_reg < lsync_end_time |=> line_sync_out)
    else $error("line sync pulse missing inside its window");
  a_lsync_off: assert property (
    pix_cnt_reg >= lsync_end_time |=> !line_sync_out)
    else $error("line sync pulse past its end time");

  a_keep_lsync_hi: assert property (
    !wr_lsync_end_hi |=> $stable(lsync_end_hi_reg))
    else $error("line sync end high bits changed without a write");
  a_keep_filter: assert property (
    !wr_filter_adj |=> $stable(filter_adj_reg))
    else $error("loop filter adjust changed without a write");
  a_keep_window: assert property (
    !wr_detect_win |=> $stable(detect_win_reg))
    else $error("detect window changed without a write");
  a_keep_start_lo: assert property (
    !wr_rst_start_lo |=> $stable(rst_start_lo_reg))
    else $error("restore start low changed without a write");
  a_keep_start_hi: assert property (
    !wr_rst_start_hi |=> $stable(rst_start_hi_reg))
    else $error("restore start high changed without a write");
  a_keep_end_lo: assert property (
    !wr_rst_end_lo |=> $stable(rst_end_lo_reg))
    else $error("restore end low changed without a write");
  a_keep_end_hi: assert property (
    !wr_rst_end_hi |=> $stable(rst_end_hi_reg))
    else $error("restore end high changed without a write");

  a_lsync_hi_readback: assert property (
    s_lsync_hi_wr_rd |=> reg_rdata == {6'h00, $past(reg_req.wdata[1:0], 3)})
    else $error("line sync end high readback wrong");
  a_start_hi_readback: assert property (
    s_start_hi_wr_rd |=> reg_rdata == {6'h00, $past(reg_req.wdata[1:0], 3)})
    else $error("restore start high readback wrong");
  a_end_hi_readback: assert property (
    s_end_hi_wr_rd |=> reg_rdata == {6'h00, $past(reg_req.wdata[1:0], 3)})
    else $error("restore end high readback wrong");
  a_start_lo_readback: assert property (
    s_start_lo_wr_rd |=> reg_rdata == $past(reg_req.wdata, 3))
    else $error("restore start low readback wrong");
  a_end_lo_readback: assert property (
    s_end_lo_wr_rd |=> reg_rdata == $past(reg_req.wdata, 3))
    else $error("restore end low readback wrong");
  a_filter_readback: assert property (
    s_filter_wr_rd |=> reg_rdata == $past(reg_req.wdata, 3))
    else $error("loop filter adjust readback wrong");
endmodule

// [test/tb.sv]
// Self-checking testbench for the line timing and line-lock PLL control registers
`timescale 1ns/1ns
module tb;
  import lltm_pkg::*;
  logic              sys_clk;
  logic              rstn;
  lltm_req_t         reg_req;
  logic [7:0]        reg_rdata;
  logic              reg_rvalid;
  logic              line_start;
  logic              hsync_in;
  logic [TIME_W-1:0] line_sync_start;
  logic [7:0]        line_sync_end_low;
  logic              line_sync_out;
  logic              black_level_restore_pulse;
  logic [7:0]        pll_filter_adjust;
  logic [7:0]        pll_detect_window;
  logic              hsync_missing;
  logic [7:0]        missing_sync_count;
  int                miscompares;
  int                compares;
  int                cycles;
  logic [7:0]        rd_val;
  logic [7:0]        exp_miss;
  logic [9:0]        rs;
  logic [9:0]        re;
  logic [7:0]        addr_tab [7] = '{8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
  logic [7:0]        rst_tab  [7] = '{8'h00, 8'h00, 8'hdd, 8'h3f, 8'h00, 8'h52, 8'h00};

  lltm_line_timing_regs dut (
    .sys_clk                   (sys_clk),
    .rstn                      (rstn),
    .reg_req                   (reg_req),
    .reg_rdata                 (reg_rdata),
    .reg_rvalid                (reg_rvalid),
    .line_start                (line_start),
    .hsync_in                  (hsync_in),
    .line_sync_start           (line_sync_start),
    .line_sync_end_low         (line_sync_end_low),
    .line_sync_out             (line_sync_out),
    .black_level_restore_pulse (black_level_restore_pulse),
    .pll_filter_adjust         (pll_filter_adjust),
    .pll_detect_window         (pll_detect_window),
    .hsync_missing             (hsync_missing),
    .missing_sync_count        (missing_sync_count)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Hang guard: whole run needs well under this many cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge sys_clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk);
    reg_req.wr = 1'b0;
  endtask

  task automatic rd(logic [7:0] a);
    @(negedge sys_clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    reg_req.rd = 1'b0;
    check("reg_rvalid", 16'(reg_rvalid), 16'h0001);
    rd_val = reg_rdata;
    @(negedge sys_clk);
    check("rvalid drop", 16'(reg_rvalid), 16'h0000);
    check("rdata hold", 16'(reg_rdata), 16'(rd_val));
  endtask

  function automatic logic [7:0] exp_read(logic [7:0] a, logic [7:0] d);
    if (a < 8'h0f || a > 8'h15) return 8'h00;
    if (a == ADDR_LSYNC_END_HI || a == ADDR_RST_START_HI || a == ADDR_RST_END_HI)
      return {6'h00, d[1:0]};
    return d;
  endfunction

  // Window is start inclusive, end exclusive; first high sample two cycles after start
  function automatic logic [15:0] exp_first(logic [9:0] s, logic [9:0] e);
    return (e > s) ? 16'(s) + 16'h0002 : 16'h0000;
  endfunction

  function automatic logic [15:0] exp_len(logic [9:0] s, logic [9:0] e);
    return (e > s) ? 16'(e - s) : 16'h0000;
  endfunction

  task automatic pulse_trial(logic [9:0] s, logic [9:0] e, logic [9:0] ls, logic [9:0] le);
    logic [15:0] fr = 16'h0;
    logic [15:0] fl = 16'h0;
    logic [15:0] nr = 16'h0;
    logic [15:0] nl = 16'h0;
    wr(ADDR_RST_START_LO, s[7:0]);
    wr(ADDR_RST_START_HI, {6'h00, s[9:8]});
    wr(ADDR_RST_END_LO, e[7:0]);
    wr(ADDR_RST_END_HI, {6'h3f, e[9:8]});
    wr(ADDR_LSYNC_END_HI, {6'h2a, le[9:8]});
    line_sync_start = ls;
    line_sync_end_low = le[7:0];
    @(negedge sys_clk);
    line_start = 1'b1;
    @(negedge sys_clk);
    line_start = 1'b0;
    for (int k = 2; k < 1100; k++) begin
      @(negedge sys_clk);
      if (black_level_restore_pulse === 1'b1 && fr == 0) fr = 16'(k);
      if (line_sync_out === 1'b1 && fl == 0) fl = 16'(k);
      nr += 16'(black_level_restore_pulse === 1'b1);
      nl += 16'(line_sync_out === 1'b1);
    end
    check("restore start", fr, exp_first(s, e));
    check("restore length", nr, exp_len(s, e));
    check("line sync start", fl, exp_first(ls, le));
    check("line sync length", nl, exp_len(ls, le));
    $display("test pulse window done");
  endtask

  task automatic miss_trial(logic [7:0] w);
    wr(ADDR_DETECT_WIN, w);
    check("detect window", 16'(pll_detect_window), 16'(w));
    @(negedge sys_clk);
    line_start = 1'b1;
    @(negedge sys_clk);
    line_start = 1'b0;
    repeat (w - 8'h01) @(negedge sys_clk);
    hsync_in = 1'b1;
    @(negedge sys_clk);
    check("accepted sync", 16'(hsync_missing), 16'h0000);
    check("count held", 16'(missing_sync_count), 16'(exp_miss));
    @(negedge sys_clk);
    hsync_in = 1'b0;
    exp_miss = exp_miss + 8'h01;
    check("late sync", 16'(hsync_missing), 16'h0001);
    check("count step", 16'(missing_sync_count), 16'(exp_miss));
    @(negedge sys_clk);
    check("miss pulse end", 16'(hsync_missing), 16'h0000);
    $display("test missing sync done");
  endtask

  initial begin
    reg_req = '0;
    rstn = 1'b0;
    line_start = 1'b0;
    hsync_in = 1'b0;
    line_sync_start = '0;
    line_sync_end_low = 8'h00;
    miscompares = 0;
    compares = 0;
    cycles = 0;
    exp_miss = 8'h00;
    void'($urandom(84));
    repeat (16) @(negedge sys_clk);
    rstn = 1'b1;
    check("filter out reset", 16'(pll_filter_adjust), 16'h0000);
    check("window out reset", 16'(pll_detect_window), 16'h00dd);
    for (int i = 0; i < 7; i++) begin
      rd(addr_tab[i]);
      check("reset value", 16'(rd_val), 16'(rst_tab[i]));
    end
    $display("test reset values done");
    for (int i = 0; i < 9; i++) begin
      logic [7:0] a;
      logic [7:0] d;
      a = (i < 7) ? addr_tab[i] : ((i == 7) ? 8'h0e : 8'h16);
      d = (i == 0) ? 8'hff : 8'($urandom);
      wr(a, d);
      rd(a);
      check("read back", 16'(rd_val), 16'(exp_read(a, d)));
    end
    wr(ADDR_FILTER_ADJ, 8'h20);
    check("filter out", 16'(pll_filter_adjust), 16'h0020);
    $display("test register access done");
    pulse_trial(10'h105, 10'h2a0, 10'h010, 10'h131);
    rs = 10'($urandom % 600);
    re = rs + 10'(1 + $urandom % 300);
    pulse_trial(rs, re, re, 10'h3ff);
    pulse_trial(10'h080, 10'h080, 10'h200, 10'h1ff);
    miss_trial(8'h10);
    miss_trial(8'(2 + $urandom % 250));
    hsync_in = 1'b1;
    repeat (300) @(negedge sys_clk);
    hsync_in = 1'b0;
    @(negedge sys_clk);
    check("count saturates", 16'(missing_sync_count), 16'h00ff);
    $display("test missing count saturation done");
    wrap_up();
  end
endmodule
